/* File: core/nor_host_pkg.sv */
// Constants and types for the parallel NOR flash host controller
//
// Behaviour
// - Host keeps only the low byte when it reads a status word.
// - Host holds hardware reset low at least the minimum reset pulse time.
// - Host waits the later of both reset-release delays before any cycle.
// - Host starts no cycle after reset until done_indicator is released.
// - Host treats a low shared done_indicator as some device still busy.
// - Host reads with address valid, select and output enable low, write high.
package nor_host_pkg;

  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int STATUS_W = 8;

  // ----------------------------------------
  // Timing, source figures in ns, derived counts in clock cycles
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_PULSE_MIN_TIME_NS = 500;
  localparam int RESET_TO_SELECT_DELAY_NS = 50;
  localparam int READY_TO_SELECT_DELAY_NS = 0;
  localparam int READ_ACCESS_NS = 70;
  localparam int WRITE_PULSE_NS = 35;
  localparam int STROBE_SETUP_NS = 10;
  localparam int STROBE_HIGH_NS = 30;

  function automatic int ns_to_min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_min_cycles

  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] RESET_PULSE_CYC = CNT_W'(ns_to_min_cycles(RESET_PULSE_MIN_TIME_NS));
  localparam int REL_NS = (RESET_TO_SELECT_DELAY_NS > READY_TO_SELECT_DELAY_NS) ?
    RESET_TO_SELECT_DELAY_NS : READY_TO_SELECT_DELAY_NS;
  localparam logic [CNT_W-1:0] RELEASE_CYC = CNT_W'(ns_to_min_cycles(REL_NS));
  localparam logic [CNT_W-1:0] READ_CYC = CNT_W'(ns_to_min_cycles(READ_ACCESS_NS));
  localparam logic [CNT_W-1:0] WRITE_CYC = CNT_W'(ns_to_min_cycles(WRITE_PULSE_NS));
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(ns_to_min_cycles(STROBE_SETUP_NS));
  localparam logic [CNT_W-1:0] RECOVER_CYC = CNT_W'(ns_to_min_cycles(STROBE_HIGH_NS));
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_STATUS,
    OP_RESET
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } request_t;

  typedef struct packed {
    logic select_n;
    logic out_en_n;
    logic wr_n;
    logic reset_n;
  } strobes_t;

  localparam strobes_t STROBES_IDLE = '{select_n: 1'b1, out_en_n: 1'b1, wr_n: 1'b1,
                                        reset_n: 1'b1};
  localparam logic [DATA_W-1:0] STATUS_MASK = 16'h00ff;

endpackage : nor_host_pkg

/* File: core/nor_sync2.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module nor_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb
  begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else
    begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule : nor_sync2
`default_nettype wire

/* File: core/nor_host.sv */
// Host controller driving a parallel NOR flash through its pins
`timescale 1ns/10ps
`default_nettype none
module nor_host (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire nor_host_pkg::request_t REQ,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [nor_host_pkg::DATA_W-1:0] RSP_DATA,
  output logic FLASH_BUSY,
  output logic [nor_host_pkg::ADDR_W-1:0] FLASH_ADDR,
  output logic [nor_host_pkg::DATA_W-1:0] FLASH_DQ_OUT,
  output logic FLASH_DQ_OE,
  input wire logic [nor_host_pkg::DATA_W-1:0] FLASH_DQ_IN,
  output nor_host_pkg::strobes_t FLASH_STROBES,
  output logic FLASH_BOOST_WP_N,
  input wire logic FLASH_DONE_IN,
  input wire logic WRITE_PROTECT_OUTER
);

  // ----------------------------------------
  // Pin input synchronisers
  // ----------------------------------------
  logic [nor_host_pkg::DATA_W:0] pins_sync;
  logic done_ready;
  logic [nor_host_pkg::DATA_W-1:0] dq_sync;

  nor_sync2 #(
    .W(nor_host_pkg::DATA_W + 1),
    .INIT({1'b0, 16'h0000})
  ) u_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .d({FLASH_DONE_IN, FLASH_DQ_IN}),
    .q(pins_sync)
  );

  // Shared wired line: low means at least one device still busy
  assign done_ready = pins_sync[nor_host_pkg::DATA_W];
  assign dq_sync = pins_sync[nor_host_pkg::DATA_W-1:0];

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RST_PULSE,
    ST_RST_WAIT,
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER
  } state_t;

  state_t state, next_state;
  logic [nor_host_pkg::CNT_W-1:0] cnt, next_cnt;
  nor_host_pkg::request_t cur, next_cur;
  nor_host_pkg::strobes_t strobes, next_strobes;
  logic [nor_host_pkg::ADDR_W-1:0] addr, next_addr;
  logic [nor_host_pkg::DATA_W-1:0] dq_out, next_dq_out;
  logic dq_oe, next_dq_oe;
  logic req_ready, next_req_ready;
  logic rsp_valid, next_rsp_valid;
  logic [nor_host_pkg::DATA_W-1:0] rsp_data, next_rsp_data;
  logic busy, next_busy;
  logic boost_wp_n, next_boost_wp_n;

  function automatic logic is_write(input nor_host_pkg::op_t op);
    return op == nor_host_pkg::OP_WRITE;
  endfunction : is_write

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_cur = cur;
    next_strobes = strobes;
    next_addr = addr;
    next_dq_out = dq_out;
    next_dq_oe = dq_oe;
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_busy = !done_ready;
    next_boost_wp_n = !WRITE_PROTECT_OUTER;
    case (state)
      ST_RST_PULSE:
      begin
        // Reset held for the whole minimum pulse, bus fully released
        next_strobes = '{select_n: 1'b1, out_en_n: 1'b1, wr_n: 1'b1, reset_n: 1'b0};
        next_dq_oe = 1'b0;
        if (cnt <= nor_host_pkg::CNT_ONE)
        begin
          next_strobes = nor_host_pkg::STROBES_IDLE;
          next_cnt = nor_host_pkg::RELEASE_CYC;
          next_state = ST_RST_WAIT;
        end
        else
        begin
          next_cnt = cnt - nor_host_pkg::CNT_ONE;
        end
      end
      ST_RST_WAIT:
      begin
        // Both the release delay and a released ready line are needed
        if (cnt > nor_host_pkg::CNT_ZERO)
        begin
          next_cnt = cnt - nor_host_pkg::CNT_ONE;
        end
        else if (done_ready)
        begin
          next_req_ready = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        next_req_ready = 1'b1;
        if (REQ_VALID && req_ready)
        begin
          next_req_ready = 1'b0;
          next_cur = REQ;
          if (REQ.op == nor_host_pkg::OP_RESET)
          begin
            next_strobes.reset_n = 1'b0;
            next_cnt = nor_host_pkg::RESET_PULSE_CYC;
            next_state = ST_RST_PULSE;
          end
          else
          begin
            next_addr = REQ.addr;
            // Only the low byte carries the command; upper byte sent as zero
            next_dq_out = is_write(REQ.op) ? (REQ.wdata & nor_host_pkg::STATUS_MASK)
                                           : nor_host_pkg::DATA_W'(0);
            next_dq_oe = is_write(REQ.op);
            next_cnt = nor_host_pkg::SETUP_CYC;
            next_state = ST_SETUP;
          end
        end
      end
      ST_SETUP:
      begin
        // Address settles before the falling edge that latches it
        if (cnt <= nor_host_pkg::CNT_ONE)
        begin
          next_strobes.select_n = 1'b0;
          if (is_write(cur.op))
          begin
            next_strobes.wr_n = 1'b0;
            next_cnt = nor_host_pkg::WRITE_CYC;
          end
          else
          begin
            next_strobes.out_en_n = 1'b0;
            next_cnt = nor_host_pkg::READ_CYC;
          end
          next_state = ST_STROBE;
        end
        else
        begin
          next_cnt = cnt - nor_host_pkg::CNT_ONE;
        end
      end
      ST_STROBE:
      begin
        if (cnt <= nor_host_pkg::CNT_ONE)
        begin
          // Data stays driven past the rising edge that latches it
          next_strobes = nor_host_pkg::STROBES_IDLE;
          if (!is_write(cur.op))
          begin
            next_rsp_valid = 1'b1;
            next_rsp_data = (cur.op == nor_host_pkg::OP_STATUS) ?
              (dq_sync & nor_host_pkg::STATUS_MASK) : dq_sync;
          end
          else
          begin
            next_rsp_valid = 1'b1;
            next_rsp_data = nor_host_pkg::DATA_W'(0);
          end
          next_cnt = nor_host_pkg::RECOVER_CYC;
          next_state = ST_RECOVER;
        end
        else
        begin
          next_cnt = cnt - nor_host_pkg::CNT_ONE;
        end
      end
      ST_RECOVER:
      begin
        next_dq_oe = 1'b0;
        if (cnt <= nor_host_pkg::CNT_ONE)
        begin
          next_req_ready = 1'b1;
          next_state = ST_IDLE;
        end
        else
        begin
          next_cnt = cnt - nor_host_pkg::CNT_ONE;
        end
      end
      default:
      begin
        next_state = ST_RST_PULSE;
        next_cnt = nor_host_pkg::RESET_PULSE_CYC;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= ST_RST_PULSE;
      cnt <= nor_host_pkg::RESET_PULSE_CYC;
      cur <= '0;
      strobes <= '{select_n: 1'b1, out_en_n: 1'b1, wr_n: 1'b1, reset_n: 1'b0};
      addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      busy <= 1'b1;
      boost_wp_n <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      cur <= next_cur;
      strobes <= next_strobes;
      addr <= next_addr;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      busy <= next_busy;
      boost_wp_n <= next_boost_wp_n;
    end
  end

  assign REQ_READY = req_ready;
  assign RSP_VALID = rsp_valid;
  assign RSP_DATA = rsp_data;
  assign FLASH_BUSY = busy;
  assign FLASH_ADDR = addr;
  assign FLASH_DQ_OUT = dq_out;
  assign FLASH_DQ_OE = dq_oe;
  assign FLASH_STROBES = strobes;
  assign FLASH_BOOST_WP_N = boost_wp_n;

endmodule : nor_host
`default_nettype wire

/* File: verification/nor_host_asserts.sv */
// Pin protocol checks for the NOR flash host controller
`timescale 1ns/10ps
`default_nettype none
module nor_host_asserts (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic REQ_READY,
  input wire logic FLASH_BUSY,
  input wire logic [nor_host_pkg::ADDR_W-1:0] FLASH_ADDR,
  input wire logic [nor_host_pkg::DATA_W-1:0] FLASH_DQ_OUT,
  input wire logic FLASH_DQ_OE,
  input wire nor_host_pkg::strobes_t FLASH_STROBES,
  input wire logic FLASH_BOOST_WP_N,
  input wire logic FLASH_DONE_IN,
  input wire logic WRITE_PROTECT_OUTER
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  // Saturating count of cycles the reset pin has been low
  logic [7:0] low_cnt;
  always_ff @(posedge CORE_CLK or negedge RST_N)
    if (!RST_N)
      low_cnt <= 8'h00;
    else if (FLASH_STROBES.reset_n)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hff)
      low_cnt <= low_cnt + 8'h01;
  a_reset_pulse_len: assert property ($rose(FLASH_STROBES.reset_n) |-> low_cnt >= 8'h32)
    else $error("reset pulse short");
  a_release_wait: assert property ($rose(FLASH_STROBES.reset_n) |->
    (FLASH_STROBES.select_n && !REQ_READY) [*5])
    else $error("cycle too soon after reset");
  a_reset_quiet: assert property (!FLASH_STROBES.reset_n |-> FLASH_STROBES.select_n &&
    FLASH_STROBES.out_en_n && FLASH_STROBES.wr_n && !FLASH_DQ_OE && !REQ_READY)
    else $error("pins active in reset");
  a_read_shape: assert property (!FLASH_STROBES.out_en_n |-> !FLASH_STROBES.select_n &&
    FLASH_STROBES.wr_n && !FLASH_DQ_OE)
    else $error("bad read strobes");
  a_write_shape: assert property (!FLASH_STROBES.wr_n |-> !FLASH_STROBES.select_n &&
    FLASH_STROBES.out_en_n && FLASH_DQ_OE && $stable(FLASH_DQ_OUT) && $stable(FLASH_ADDR))
    else $error("bad write strobes");
  a_cmd_low_byte: assert property (FLASH_DQ_OE |-> FLASH_DQ_OUT[15:8] == 8'h00)
    else $error("upper data byte driven");
  a_boost_track: assert property (1'b1 |=> FLASH_BOOST_WP_N == !$past(WRITE_PROTECT_OUTER))
    else $error("boost pin wrong");
  a_busy_follow: assert property (!FLASH_DONE_IN |-> ##3 FLASH_BUSY)
    else $error("busy not reported");
  a_ready_follow: assert property (FLASH_DONE_IN |-> ##3 !FLASH_BUSY)
    else $error("ready not reported");
endmodule : nor_host_asserts
bind nor_host nor_host_asserts nor_host_asserts_inst (.CORE_CLK, .RST_N, .REQ_READY,
  .FLASH_BUSY, .FLASH_ADDR, .FLASH_DQ_OUT, .FLASH_DQ_OE, .FLASH_STROBES, .FLASH_BOOST_WP_N,
  .FLASH_DONE_IN, .WRITE_PROTECT_OUTER);
`default_nettype wire

/* File: verification/nor_flash_model.sv */
// Behavioural parallel NOR flash at the host pins
`timescale 1ns/10ps
`default_nettype none
module nor_flash_model (
  input wire logic [nor_host_pkg::ADDR_W-1:0] addr,
  input wire logic [nor_host_pkg::DATA_W-1:0] dq_host,
  input wire nor_host_pkg::strobes_t pins,
  input wire logic boost_n,
  input wire logic supply_ok,
  output logic [nor_host_pkg::DATA_W-1:0] dq_dev,
  output logic done
);
  logic [15:0] mem [int];
  logic [22:0] cmd_addr;
  logic [15:0] rd;
  logic drive;
  logic wr_on;
  realtime busy_end = 0.0;
  assign drive = pins.reset_n && !pins.select_n && !pins.out_en_n && pins.wr_n;
  assign wr_on = pins.reset_n && !pins.select_n && !pins.wr_n;
  always @(addr, pins, done)
    rd = mem.exists(int'(addr)) ? mem[int'(addr)] : ~addr[15:0];
  // Released lines show the inverse so a stale sample never matches
  assign dq_dev = drive ? rd : ~rd;
  always @(posedge wr_on) cmd_addr = addr;
  // Busy is a deadline, so a write arriving during busy is never missed
  always @(negedge wr_on)
  begin
    // Upper byte is junk so status masking shows
    if (supply_ok)
    begin
      if (boost_n || (cmd_addr[22:16] != 7'h00 && cmd_addr[22:16] != 7'h7f))
        mem[int'(cmd_addr)] = {8'h5a, dq_host[7:0]};
      busy_end = $realtime + 300.0;
    end
  end
  // Losing supply mid-operation aborts it and spoils the target word
  always @(negedge supply_ok)
    if (done === 1'b0)
    begin
      mem[int'(cmd_addr)] = 16'hxxxx;
      busy_end = $realtime;
    end
  always @(posedge pins.reset_n) busy_end = $realtime + 200.0;
  // Ticks sit off the clock grid so the line never moves on a sampling edge
  initial
  begin
    #0.5;
    forever
    begin
      done = ($realtime >= busy_end);
      #1;
    end
  end
endmodule : nor_flash_model
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the NOR flash host controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {
    logic w;
    nor_host_pkg::op_t op;
    logic [22:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } row_t;
  localparam row_t ROWS [10] = '{
    '{1'b0, nor_host_pkg::OP_WRITE, 23'h000100, 16'hff3c, 16'h0000},
    '{1'b0, nor_host_pkg::OP_READ, 23'h000100, 16'h0000, 16'h5a3c},
    '{1'b0, nor_host_pkg::OP_STATUS, 23'h000100, 16'h0000, 16'h003c},
    '{1'b0, nor_host_pkg::OP_READ, 23'h000200, 16'h0000, 16'hfdff},
    '{1'b1, nor_host_pkg::OP_WRITE, 23'h7f8004, 16'h0011, 16'h0000},
    '{1'b1, nor_host_pkg::OP_READ, 23'h7f8004, 16'h0000, 16'h7ffb},
    '{1'b1, nor_host_pkg::OP_WRITE, 23'h400000, 16'h0022, 16'h0000},
    '{1'b1, nor_host_pkg::OP_READ, 23'h400000, 16'h0000, 16'h5a22},
    '{1'b0, nor_host_pkg::OP_WRITE, 23'h000008, 16'h0033, 16'h0000},
    '{1'b0, nor_host_pkg::OP_READ, 23'h000008, 16'h0000, 16'h5a33}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic wpo = 1'b0;
  logic supply_ok = 1'b1;
  nor_host_pkg::request_t req = '0;
  logic req_ready;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic busy;
  logic [22:0] faddr;
  logic [15:0] dq_out;
  logic dq_oe;
  logic [15:0] dq_in;
  nor_host_pkg::strobes_t strobes;
  logic boost_n;
  logic done;
  int fails = 0;
  int check_count = 0;
  nor_host nor_host_inst (.CORE_CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ(req),
    .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .FLASH_BUSY(busy),
    .FLASH_ADDR(faddr), .FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE(dq_oe), .FLASH_DQ_IN(dq_in),
    .FLASH_STROBES(strobes), .FLASH_BOOST_WP_N(boost_n), .FLASH_DONE_IN(done),
    .WRITE_PROTECT_OUTER(wpo));
  nor_flash_model nor_flash_model_inst (.addr(faddr), .dq_host(dq_out), .pins(strobes),
    .boost_n(boost_n), .supply_ok(supply_ok), .dq_dev(dq_in), .done(done));
  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Reset ops answer with ready instead of a response pulse
  task automatic run(input nor_host_pkg::op_t op, input logic [22:0] a, input logic [15:0] d,
                     input logic [15:0] e);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op: op, addr: a, wdata: d};
    do
      @(posedge clk);
    while (req_ready !== 1'b1 && ++n < 500);
    req_valid <= 1'b0;
    do
      @(posedge clk);
    while ((op == nor_host_pkg::OP_RESET ? req_ready : rsp_valid) !== 1'b1 && ++n < 1000);
    // A handshake that never completes is a failure in its own right
    if (n >= 1000)
      fails++;
    if (op == nor_host_pkg::OP_RESET)
      check(done, 1'b1);
    else
      check(rsp_data, e);
  endtask : run
  initial
  begin
    forever #5 clk = ~clk;
  end
  initial
  begin
    #50000;
    fails++;
    final_report();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i])
    begin
      @(posedge clk);
      wpo <= ROWS[i].w;
      run(ROWS[i].op, ROWS[i].a, ROWS[i].d, ROWS[i].e);
    end
    repeat (40) @(posedge clk);
    run(nor_host_pkg::OP_WRITE, 23'h000010, 16'h0044, 16'h0000);
    repeat (4) @(posedge clk);
    check(busy, 1'b1);
    repeat (35) @(posedge clk);
    check(busy, 1'b0);
    supply_ok <= 1'b0;
    run(nor_host_pkg::OP_WRITE, 23'h000020, 16'h0055, 16'h0000);
    supply_ok <= 1'b1;
    run(nor_host_pkg::OP_READ, 23'h000020, 16'h0000, 16'hffdf);
    run(nor_host_pkg::OP_RESET, 23'h000000, 16'h0000, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check({req_ready, dq_oe, strobes.reset_n}, 3'b000);
    rst_n <= 1'b1;
    run(nor_host_pkg::OP_READ, 23'h000010, 16'h0000, 16'h5a44);
    final_report();
  end
endmodule : tb
`default_nettype wire
